// ### core/clkchg_consts.svh
// Timing counts and encodings for the clock change controller
`ifndef CLKCHG_CONSTS_SVH
`define CLKCHG_CONSTS_SVH
`define CLK_PERIOD_NS 50
`define CKE_LOW_HOLD_CYC 2
`define STABLE_PRE_CKE_CYC 2
`define TXP_NS 100
`define TXP_CYC ((`TXP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NOP_CA_BITS 3'h7
`define CA_WIDTH 10
`endif

// ### core/clkchg_pkg.sv
// Types for the clock change controller
package clkchg_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_PD_ENTRY,
        ST_HOLD,
        ST_CHANGE,
        ST_RESTART,
        ST_EXIT,
        ST_XP
    } state_e;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic [9:0] ca;
    } cmd_bus_s;
endpackage : clkchg_pkg

// ### core/clkchg_ctrl.sv
// Host-side controller that changes or stops the memory clock safely
// How it works
// - CKE-low change needs refresh met, REFab only
// - Activates, precharges and tRCD/tRP done first
// - Keep old clock two cycles after CKE low
// - Two clean clock cycles before CKE high
// - Each clock period within tCK limits
// - Reprogram WR, RL via MRW afterwards; code only raises mrw_needed, issues no MRW
// - Stopped clock: CK low, CK# high
// - CKE-high change after all commands finish
// - CKE-high change after all command timings
// - CS# high during CKE-high change
// - NOP only when CKE steady two cycles
// - Power-down entry then NOP next cycle
// - Wait tXP after CKE high before commands
`timescale 1ns/1ps
`include "clkchg_consts.svh"
module clkchg_ctrl #(
    parameter int MAX_DIV = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic change_req,
    input wire logic keep_cke_high,
    input wire logic stop_clock,
    input wire logic [7:0] new_div,
    input wire logic mem_quiet,
    output logic change_ack,
    output logic ready,
    output logic mrw_needed,
    output logic ck,
    output logic ck_n,
    output clkchg_pkg::cmd_bus_s cmd
);
    // Counts are held in eight bits, and the bus struct must match its width
    if (MAX_DIV < 1 || MAX_DIV > 255) begin : g_bad_div
        $error("MAX_DIV out of range");
    end
    if ($bits(clkchg_pkg::cmd_bus_s) != `CA_WIDTH + 2) begin : g_bad_bus
        $error("command bus width does not match CA_WIDTH");
    end

    localparam logic [7:0] CKE_HOLD = 8'(`CKE_LOW_HOLD_CYC);
    localparam logic [7:0] PRE_CKE = 8'(`STABLE_PRE_CKE_CYC);
    localparam logic [7:0] XP_CYC = 8'(`TXP_CYC);

    clkchg_pkg::state_e state_q;
    logic [7:0] div_q;
    logic [7:0] div_cnt_q;
    logic [7:0] cyc_cnt_q;
    logic ck_q;
    logic ck_rise;
    logic cke_hi_mode_q;
    logic stop_q;
    logic running;

    // Clamped divider keeps each period inside the allowed window
    function automatic logic [7:0] clamp_div(input logic [7:0] d);
        if (d == 8'h00) begin
            clamp_div = 8'h01;
        end else if (d > 8'(MAX_DIV)) begin
            clamp_div = 8'(MAX_DIV);
        end else begin
            clamp_div = d;
        end
    endfunction : clamp_div

    // A stop parks the pair only after the high phase ends, so the last
    // pulse keeps its full width; the stopped level is the low phase
    assign running = (state_q != clkchg_pkg::ST_CHANGE) || !stop_q || ck_q;
    assign ck_rise = running && !ck_q && (div_cnt_q == 8'h00);

    // Clock generator: half period is div_q system cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_q <= 8'h00;
            ck_q <= 1'b0;
        end else if (!running) begin
            div_cnt_q <= 8'h00;
            ck_q <= 1'b0;
        end else if (div_cnt_q == 8'h00) begin
            div_cnt_q <= div_q - 8'h01;
            ck_q <= !ck_q;
        end else begin
            div_cnt_q <= div_cnt_q - 8'h01;
        end
    end

    // Divider reloads from new_div on every cycle in ST_CHANGE, whether or not the clock is parked
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= 8'h01;
        end else if (state_q == clkchg_pkg::ST_CHANGE) begin
            div_q <= clamp_div(new_div);
        end
    end

    // Sequencer: take, hold old clock, park, restart, exit latency
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= clkchg_pkg::ST_RUN;
            cyc_cnt_q <= 8'h00;
            cke_hi_mode_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            case (state_q)
                clkchg_pkg::ST_RUN: begin
                    // Caller vouches that bursts, timings, refresh are done
                    if (change_req && mem_quiet && ck_rise) begin
                        cke_hi_mode_q <= keep_cke_high;
                        stop_q <= stop_clock;
                        cyc_cnt_q <= 8'h00;
                        state_q <= keep_cke_high ? clkchg_pkg::ST_HOLD
                                                 : clkchg_pkg::ST_PD_ENTRY;
                    end
                end
                clkchg_pkg::ST_PD_ENTRY: begin
                    // CKE drops on this edge while the old clock keeps running
                    if (ck_rise) begin
                        state_q <= clkchg_pkg::ST_HOLD;
                    end
                end
                clkchg_pkg::ST_HOLD: begin
                    if (ck_rise) begin
                        if (cyc_cnt_q + 8'h01 >= CKE_HOLD) begin
                            state_q <= clkchg_pkg::ST_CHANGE;
                        end
                        cyc_cnt_q <= cyc_cnt_q + 8'h01;
                    end
                end
                clkchg_pkg::ST_CHANGE: begin
                    if (!change_req) begin
                        cyc_cnt_q <= 8'h00;
                        state_q <= clkchg_pkg::ST_RESTART;
                    end
                end
                clkchg_pkg::ST_RESTART: begin
                    // Counting one extra rise gives two whole clean cycles
                    if (ck_rise) begin
                        if (cyc_cnt_q >= PRE_CKE) begin
                            cyc_cnt_q <= 8'h00;
                            state_q <= cke_hi_mode_q ? clkchg_pkg::ST_XP
                                                     : clkchg_pkg::ST_EXIT;
                        end else begin
                            cyc_cnt_q <= cyc_cnt_q + 8'h01;
                        end
                    end
                end
                clkchg_pkg::ST_EXIT: begin
                    if (ck_rise) begin
                        cyc_cnt_q <= 8'h00;
                        state_q <= clkchg_pkg::ST_XP;
                    end
                end
                clkchg_pkg::ST_XP: begin
                    // Latency counted in ck rises, so a slow clock waits longer
                    if (ck_rise) begin
                        if (cyc_cnt_q + 8'h01 >= XP_CYC) begin
                            state_q <= clkchg_pkg::ST_RUN;
                        end
                        cyc_cnt_q <= cyc_cnt_q + 8'h01;
                    end
                end
                default: state_q <= clkchg_pkg::ST_RUN;
            endcase
        end
    end

    // Command pins: CKE low from power-down entry to exit, CS# high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd.cke <= 1'b1;
            cmd.cs_n <= 1'b1;
            cmd.ca <= `CA_WIDTH'h3FF;
        end else begin
            case (state_q)
                clkchg_pkg::ST_RUN: cmd.cke <= 1'b1;
                clkchg_pkg::ST_PD_ENTRY,
                clkchg_pkg::ST_HOLD,
                clkchg_pkg::ST_CHANGE,
                clkchg_pkg::ST_RESTART: cmd.cke <= cke_hi_mode_q;
                clkchg_pkg::ST_EXIT,
                clkchg_pkg::ST_XP: cmd.cke <= 1'b1;
                default: cmd.cke <= 1'b1;
            endcase
            // Both NOP encodings held: CS# high and CA0-2 high
            cmd.cs_n <= 1'b1;
            cmd.ca <= {7'h7F, `NOP_CA_BITS};
        end
    end

    // Pair from one register so the two halves never overlap
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ck <= 1'b0;
            ck_n <= 1'b1;
        end else begin
            ck <= ck_q;
            ck_n <= !ck_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            change_ack <= 1'b0;
            ready <= 1'b1;
            mrw_needed <= 1'b0;
        end else begin
            change_ack <= (state_q == clkchg_pkg::ST_CHANGE);
            // Ready drops as soon as a request is seen, even a refused one
            ready <= (state_q == clkchg_pkg::ST_RUN) && !change_req;
            // Advisory only: the caller picks which settings to rewrite
            if (state_q == clkchg_pkg::ST_CHANGE) begin
                mrw_needed <= 1'b1;
            end else if (change_req && state_q == clkchg_pkg::ST_RUN) begin
                mrw_needed <= 1'b0;
            end
        end
    end
endmodule : clkchg_ctrl

// ### test/clkchg_ctrl_checker.sv
// Memory-side protocol checks for the clock change controller
`timescale 1ns/1ps
module clkchg_ctrl_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic change_req,
    input wire logic mem_quiet,
    input wire logic change_ack,
    input wire logic ready,
    input wire logic ck,
    input wire logic ck_n,
    input wire clkchg_pkg::cmd_bus_s cmd
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ck_pair_a: assert property (ck_n != ck)
        else $error("clock pair not complementary");
    cs_high_a: assert property (cmd.cs_n)
        else $error("chip select driven low");
    ca_nop_a: assert property (cmd.ca[2:0] == 3'h7)
        else $error("command bits not a no-operation");
    cke_hold_a: assert property ($fell(cmd.cke) |-> !change_ack [*3])
        else $error("clock parked too soon after enable low");
    cke_restart_a: assert property ($rose(cmd.cke) |-> !change_req)
        else $error("enable raised while change still requested");
    xp_wait_a: assert property ($rose(cmd.cke) |-> !ready [*3])
        else $error("ready before exit latency");
    ack_ready_a: assert property (change_ack |-> !ready)
        else $error("ready while clock is parked");
    quiet_gate_a: assert property (ready && !mem_quiet |=>
        cmd.cke && !change_ack)
        else $error("change taken while memory busy");
    cover property ($rose(change_ack));
    cover property ($fell(cmd.cke));
    cover property ($rose(ready));
endmodule : clkchg_ctrl_checker

// ### test/lpddr2_dev_model.sv
// Behavioural memory device decoding the command bus
`timescale 1ns/1ps
module lpddr2_dev_model (
    input wire logic ck,
    input wire clkchg_pkg::cmd_bus_s cmd,
    output logic [15:0] reg_cmds = 16'h0000
);
    logic cke_prev = 1'b1;
    // Only a steady enable lets an edge decode anything at all
    always @(posedge ck) begin
        if (cmd.cke && cke_prev) begin
            if (!cmd.cs_n && cmd.ca[2:0] != 3'h7) begin
                reg_cmds <= reg_cmds + 16'h0001;
            end
        end
        cke_prev <= cmd.cke;
    end
endmodule : lpddr2_dev_model

// ### test/lpddr2_clock_change_nop_test.sv
// Self-checking bench for the clock change controller
`timescale 1ns/1ps
module lpddr2_clock_change_nop_test;
    logic clk = 1'b0, sys_rst = 1'b1, change_req = 1'b0, mem_quiet = 1'b1;
    logic keep_cke_high = 1'b0, stop_clock = 1'b0, ck_q = 1'b0, rdy_q = 1'b1;
    logic change_ack, ready, mrw_needed, ck, ck_n;
    logic [7:0] new_div = 8'h01, run_q = 8'h01, half_q = 8'h01, exp_q[$];
    logic [7:0] rises_q = 8'h00;
    logic [15:0] dev_cmds;
    logic [31:0] seed = 32'h5FBD;
    clkchg_pkg::cmd_bus_s cmd;
    int fail_count = 0, check_count = 0;
    always #25 clk = ~clk;
    clkchg_ctrl #(.MAX_DIV(8)) dut (.clk(clk), .sys_rst(sys_rst),
        .change_req(change_req), .keep_cke_high(keep_cke_high),
        .stop_clock(stop_clock), .new_div(new_div), .mem_quiet(mem_quiet),
        .change_ack(change_ack), .ready(ready), .mrw_needed(mrw_needed),
        .ck(ck), .ck_n(ck_n), .cmd(cmd));
    lpddr2_dev_model dev (.ck(ck), .cmd(cmd), .reg_cmds(dev_cmds));
    function automatic logic [31:0] rnd(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : rnd
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %0h got %0h", n, e, g);
        end
    endtask : cmp
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick
    task automatic await(input logic want_ack);
        for (int n = 0; n < 500; n++) begin
            if ((want_ack ? change_ack : ready) === 1'b1) return;
            tick(1);
        end
        cmp("timeout", 8'h00, 8'h01);
        finish_test();
    endtask : await
    task automatic change(input logic [7:0] d, input logic k, input logic s);
        logic [7:0] e;
        e = (d == 8'h00) ? 8'h01 : (d > 8'h08) ? 8'h08 : d;
        await(1'b0);
        new_div = d;
        keep_cke_high = k;
        stop_clock = s;
        change_req = 1'b1;
        await(1'b1);
        cmp("cke parked", {7'h00, k}, {7'h00, cmd.cke});
        // The old high phase may last up to MAX_DIV cycles before the park
        tick(8);
        repeat (4) begin
            if (s) cmp("stopped pair", 8'h02, {6'h00, ck_n, ck});
            tick(1);
        end
        exp_q.push_back(e);
        change_req = 1'b0;
        await(1'b0);
        tick(1);
        $display("test change div %0d keep %0d stop %0d done", d, k, s);
    endtask : change
    // Half period measured in clk cycles; checked once restart completes
    always @(posedge clk) begin
        ck_q <= ck;
        rdy_q <= ready;
        run_q <= (ck != ck_q) ? 8'h01 : run_q + 8'h01;
        if (ck != ck_q) half_q <= run_q;
        if (change_ack) rises_q <= 8'h00;
        else if (ck && !ck_q) rises_q <= rises_q + 8'h01;
        if (ready && !rdy_q && exp_q.size() > 0) begin
            cmp("restart clocks", 8'h01, {7'h00, rises_q >= 8'h04});
            cmp("half period", exp_q.pop_front(), half_q);
            cmp("mrw flag", 8'h01, {7'h00, mrw_needed});
        end
    end
    initial begin
        logic [7:0] divs[4] = '{8'h01, 8'h03, 8'h00, 8'h0C};
        repeat (2) @(posedge clk);
        #5 sys_rst = 1'b0;
        tick(2);
        mem_quiet = 1'b0;
        change_req = 1'b1;
        tick(20);
        cmp("refused ack", 8'h00, {7'h00, change_ack});
        cmp("refused cke", 8'h01, {7'h00, cmd.cke});
        change_req = 1'b0;
        tick(2);
        mem_quiet = 1'b1;
        $display("test refuse done");
        for (int i = 0; i < 8; i++) begin
            seed = rnd(seed);
            if (i < 4) change(divs[i], i[0], i[1]);
            else change({5'h00, seed[10:8]}, seed[0], seed[1]);
        end
        tick(5);
        cmp("device cmds", 8'h00, dev_cmds[7:0]);
        finish_test();
    end
endmodule : lpddr2_clock_change_nop_test
bind clkchg_ctrl clkchg_ctrl_checker chk (.clk(clk), .sys_rst(sys_rst),
    .change_req(change_req), .mem_quiet(mem_quiet), .change_ack(change_ack),
    .ready(ready), .ck(ck), .ck_n(ck_n), .cmd(cmd));
